//--- verilog/i2c_slave_pkg.sv
// Constants for the two-wire slave serial port and its register map.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
package i2c_slave_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0c;
    // serial_ctrl0_reg fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int ENABLE_BIT = 1;
    localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
    localparam logic [7:0] CTRL0_RESET = 8'he0;
    // serial_ctrl1_reg fields
    localparam int MATCHED_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int TXSEL_BIT = 4;
    localparam int ACKSEND_BIT = 3;
    localparam int DIR_BIT = 2;
    localparam int ACKRCV_BIT = 0;
    localparam logic ACKSEND_RESET = 1'b0;
    localparam logic TXSEL_RESET = 1'b0;
    // Own address and data reset values
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Bits per byte and address field width
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int ADDR_BITS = 7;
    // Register selector
    typedef enum logic [2:0] {
        SEL_NONE, SEL_CTRL0, SEL_CTRL1, SEL_ADDR, SEL_DATA
    } reg_sel_type;
    // Bus-side engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_RX, ST_RX_ACK,
        ST_TX, ST_TX_ACK, ST_WAIT_STOP
    } bus_state_type;
endpackage

//--- verilog/pin_sync.sv
// Two-flop synchroniser for the bus pins.
// Assumes asynchronous inputs; only the second stage is read outside.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // Idle bus level is high, so reset to ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '1;
            syncOut <= '1;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule

//--- verilog/i2c_slave_serial_port.sv
// Two-wire slave serial port with AHB-Lite register access.
// Assumes an external master drives SCL and makes START and STOP;
// pins are open drain, resolved outside from the enables.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module i2c_slave_serial_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOeN,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic irqReq
);
    logic [7:0] ctrl0_r;
    logic [7:0] ownAddr_r;
    logic [7:0] data_r;
    logic txSel_r, ackToSend_r;
    logic matched_r, busy_r, dir_r, ackRcv_r;
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    i2c_slave_pkg::bus_state_type state_r;
    i2c_slave_pkg::reg_sel_type wrSel_r;
    logic wrPend_r;
    logic [1:0] pinS;
    logic sclS, sdaS, sclP_r, sdaP_r;
    logic sclRise, sclFall, startDet, stopDet, active;
    logic addrDone, matchHit, rxDone, ackSample, txByteEnd;
    logic addrOk, rdData, wrData, swData, relEvt;
    logic [7:0] txLoad, ctrl1Val;

    // Map a byte offset onto a register; shared by read and write
    function automatic i2c_slave_pkg::reg_sel_type decode(
        input logic [31:0] a);
        if (a == {24'h000000, i2c_slave_pkg::OFS_CTRL0}) begin
            return i2c_slave_pkg::SEL_CTRL0;
        end else if (a == {24'h000000, i2c_slave_pkg::OFS_CTRL1}) begin
            return i2c_slave_pkg::SEL_CTRL1;
        end else if (a == {24'h000000, i2c_slave_pkg::OFS_ADDR}) begin
            return i2c_slave_pkg::SEL_ADDR;
        end else if (a == {24'h000000, i2c_slave_pkg::OFS_DATA}) begin
            return i2c_slave_pkg::SEL_DATA;
        end else begin
            return i2c_slave_pkg::SEL_NONE;
        end
    endfunction

    // Pins come from another domain
    pin_sync #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({sclIn, sdaIn}),
        .syncOut(pinS)
    );
    assign sclS = pinS[1];
    assign sdaS = pinS[0];

    // Previous levels for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclP_r <= 1'b1;
            sdaP_r <= 1'b1;
        end else begin
            sclP_r <= sclS;
            sdaP_r <= sdaS;
        end
    end

    // Bus events
    assign active = ctrl0_r[i2c_slave_pkg::ENABLE_BIT] &&
        (ctrl0_r[i2c_slave_pkg::MODE_HI:i2c_slave_pkg::MODE_LO] ==
         i2c_slave_pkg::MODE_TWO_WIRE);
    assign sclRise = sclS && !sclP_r;
    assign sclFall = !sclS && sclP_r;
    assign startDet = active && sclS && sclP_r && sdaP_r && !sdaS;
    assign stopDet = active && sclS && sclP_r && !sdaP_r && sdaS;
    assign addrDone = state_r == i2c_slave_pkg::ST_ADDR && sclFall &&
        cnt_r == i2c_slave_pkg::BYTE_BITS;
    assign matchHit = addrDone && !startDet && (shift_r[7:1] ==
        ownAddr_r[7:1]);
    assign rxDone = state_r == i2c_slave_pkg::ST_RX && sclFall &&
        cnt_r == i2c_slave_pkg::BYTE_BITS && !startDet;
    assign ackSample = state_r == i2c_slave_pkg::ST_TX_ACK && sclRise;
    assign txByteEnd = state_r == i2c_slave_pkg::ST_TX_ACK && sclFall &&
        !startDet;

    // Software touches of the data register release a stretched clock
    assign addrOk = hsel && hready && htrans[1];
    assign rdData = addrOk && !hwrite &&
        decode(haddr) == i2c_slave_pkg::SEL_DATA;
    assign wrData = wrPend_r && wrSel_r == i2c_slave_pkg::SEL_DATA;
    assign swData = rdData || wrData;
    assign relEvt = state_r == i2c_slave_pkg::ST_HOLD && swData &&
        !startDet && !stopDet && active;
    // A byte written in the releasing cycle goes straight out
    assign txLoad = wrData ? hwdata[7:0] : data_r;

    assign ctrl1Val = {matched_r, busy_r, 1'b0, txSel_r, ackToSend_r,
        dir_r, 1'b0, ackRcv_r};

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // Address phase capture and read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrSel_r <= i2c_slave_pkg::SEL_NONE;
            hrdata <= 32'h00000000;
        end else begin
            wrPend_r <= addrOk && hwrite;
            wrSel_r <= addrOk ? decode(haddr) : i2c_slave_pkg::SEL_NONE;
            if (addrOk && !hwrite) begin
                case (decode(haddr))
                    i2c_slave_pkg::SEL_CTRL0: hrdata <= {24'h0, ctrl0_r};
                    i2c_slave_pkg::SEL_CTRL1: hrdata <= {24'h0, ctrl1Val};
                    i2c_slave_pkg::SEL_ADDR: hrdata <= {24'h0, ownAddr_r};
                    i2c_slave_pkg::SEL_DATA: hrdata <= {24'h0, data_r};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Software-written control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_r <= i2c_slave_pkg::CTRL0_RESET;
            ownAddr_r <= i2c_slave_pkg::ADDR_RESET;
            txSel_r <= i2c_slave_pkg::TXSEL_RESET;
            ackToSend_r <= i2c_slave_pkg::ACKSEND_RESET;
        end else if (wrPend_r) begin
            if (wrSel_r == i2c_slave_pkg::SEL_CTRL0) begin
                ctrl0_r <= hwdata[7:0];
            end else if (wrSel_r == i2c_slave_pkg::SEL_ADDR) begin
                ownAddr_r <= hwdata[7:0];
            end else if (wrSel_r == i2c_slave_pkg::SEL_CTRL1) begin
                txSel_r <= hwdata[i2c_slave_pkg::TXSEL_BIT];
                ackToSend_r <= hwdata[i2c_slave_pkg::ACKSEND_BIT];
            end
        end
    end

    // Shared data register; a received byte beats a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= i2c_slave_pkg::DATA_RESET;
        end else if (rxDone) begin
            data_r <= shift_r;
        end else if (wrData) begin
            data_r <= hwdata[7:0];
        end
    end

    // Status flags; hardware set wins over software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            matched_r <= 1'b0;
            dir_r <= 1'b0;
            ackRcv_r <= 1'b0;
        end else begin
            if (startDet) begin
                busy_r <= 1'b1;
            end else if (stopDet || !active) begin
                busy_r <= 1'b0;
            end
            if (matchHit) begin
                matched_r <= 1'b1;
                dir_r <= shift_r[0];
            end else if (swData || startDet) begin
                matched_r <= 1'b0;
            end
            if (ackSample) begin
                ackRcv_r <= sdaS;
            end
        end
    end

    // One interrupt pulse for all three sources: address match, received byte, sent byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqReq <= 1'b0;
        end else begin
            irqReq <= matchHit || rxDone || txByteEnd;
        end
    end

    // Bus engine; the slave never drives SDA low while SCL is high
    // outside a data or ack slot, so it cannot make a START
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= i2c_slave_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sdaOeN <= 1'b1;
            sclOeN <= 1'b1;
        end else if (!active || stopDet) begin
            state_r <= i2c_slave_pkg::ST_IDLE;
            sdaOeN <= 1'b1;
            sclOeN <= 1'b1;
        end else if (startDet) begin
            state_r <= i2c_slave_pkg::ST_ADDR;
            cnt_r <= 4'h0;
            sdaOeN <= 1'b1;
            sclOeN <= 1'b1;
        end else begin
            case (state_r)
                i2c_slave_pkg::ST_ADDR: begin
                    if (sclRise) begin
                        shift_r <= {shift_r[6:0], sdaS};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (addrDone) begin
                        if (matchHit) begin
                            sdaOeN <= 1'b0;
                            state_r <= i2c_slave_pkg::ST_ADDR_ACK;
                        end else begin
                            state_r <= i2c_slave_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                i2c_slave_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        sdaOeN <= 1'b1;
                        sclOeN <= 1'b0;
                        state_r <= i2c_slave_pkg::ST_HOLD;
                    end
                end
                i2c_slave_pkg::ST_HOLD: begin
                    if (relEvt) begin
                        sclOeN <= 1'b1;
                        if (txSel_r) begin
                            shift_r <= txLoad;
                            sdaOeN <= txLoad[7];
                            cnt_r <= 4'h1;
                            state_r <= i2c_slave_pkg::ST_TX;
                        end else begin
                            cnt_r <= 4'h0;
                            state_r <= i2c_slave_pkg::ST_RX;
                        end
                    end
                end
                i2c_slave_pkg::ST_RX: begin
                    if (sclRise) begin
                        shift_r <= {shift_r[6:0], sdaS};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (rxDone) begin
                        sdaOeN <= ackToSend_r;
                        state_r <= i2c_slave_pkg::ST_RX_ACK;
                    end
                end
                i2c_slave_pkg::ST_RX_ACK: begin
                    if (sclFall) begin
                        sdaOeN <= 1'b1;
                        if (!ackToSend_r) begin
                            sclOeN <= 1'b0;
                            state_r <= i2c_slave_pkg::ST_HOLD;
                        end else begin
                            state_r <= i2c_slave_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                i2c_slave_pkg::ST_TX: begin
                    if (sclFall) begin
                        if (cnt_r == i2c_slave_pkg::BYTE_BITS) begin
                            sdaOeN <= 1'b1;
                            state_r <= i2c_slave_pkg::ST_TX_ACK;
                        end else begin
                            sdaOeN <= shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                i2c_slave_pkg::ST_TX_ACK: begin
                    if (txByteEnd) begin
                        if (!ackRcv_r) begin
                            sclOeN <= 1'b0;
                            state_r <= i2c_slave_pkg::ST_HOLD;
                        end else begin
                            state_r <= i2c_slave_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                default: begin
                    sdaOeN <= 1'b1;
                    sclOeN <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence matchSeq;
        matchHit;
    endsequence
    sequence ackSlotSeq;
        !sdaOeN [*1] ##1 (sdaOeN || !sclOeN);
    endsequence

    start_busy_a: assert property (startDet |=> busy_r)
        else $error("START did not set busy");
    stop_busy_a: assert property (stopDet && !startDet |=> !busy_r)
        else $error("STOP did not clear busy");
    match_irq_a: assert property (matchSeq |=> matched_r ##0 irqReq)
        else $error("Match did not flag and interrupt");
    dir_capture_a: assert property (
        matchSeq |=> dir_r == $past(shift_r[0]))
        else $error("Direction bit not captured");
    addr_ack_a: assert property (
        matchSeq |=> !sdaOeN until (state_r != i2c_slave_pkg::ST_ADDR_ACK))
        else $error("Address ack not driven");
    byte_irq_a: assert property ((rxDone || txByteEnd) |=> irqReq)
        else $error("Byte end gave no interrupt");
    scl_hold_a: assert property (
        state_r == i2c_slave_pkg::ST_HOLD && !relEvt && active &&
        !startDet && !stopDet |=> !sclOeN)
        else $error("SCL not held in hold state");
    rx_store_a: assert property (rxDone |=> data_r == $past(shift_r))
        else $error("Received byte not stored");
    rx_ack_a: assert property (
        rxDone |=> sdaOeN == $past(ackToSend_r))
        else $error("Wrong receive ack level");
    tx_first_a: assert property (
        relEvt && txSel_r |=> sdaOeN == $past(txLoad[7]) && sclOeN)
        else $error("First bit not MSB");
    tx_nack_a: assert property (
        txByteEnd && ackRcv_r |=> (sdaOeN && sclOeN) [*2])
        else $error("SDA not released after nack");
    ack_sample_a: assert property (
        ackSample |=> ackRcv_r == $past(sdaS))
        else $error("Master ack not sampled");
    mode_gate_a: assert property (
        !active |=> state_r == i2c_slave_pkg::ST_IDLE && sdaOeN)
        else $error("Engine active outside two-wire mode");
endmodule

//--- sim/i2c_master_model.sv
// Behavioural two-wire bus master that drives SCL and SDA open drain.
// Assumes pulled-up lines that the bench resolves from all enables.
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic clk,
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic sclOeN,
    output logic sdaOeN
);
    // Both lines are released until a frame starts
    initial begin
        sclOeN = 1'b1;
        sdaOeN = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Only this side ever makes a START
    task automatic start_cond();
        sdaOeN <= 1'b1;
        sclOeN <= 1'b1;
        tick(4);
        sdaOeN <= 1'b0;
        tick(4);
        sclOeN <= 1'b0;
        tick(2);
    endtask

    // Ends every frame, unanswered address included
    task automatic stop_cond();
        sdaOeN <= 1'b0;
        tick(2);
        sclOeN <= 1'b1;
        tick(4);
        sdaOeN <= 1'b1;
        tick(4);
    endtask

    // One 400 ns clock; a stretched SCL delays the high half,
    // and only the bench timeout ends a stretch that never lets go
    task automatic clock_bit(input logic b, output logic r);
        sdaOeN <= b;
        tick(2);
        sclOeN <= 1'b1;
        tick(1);
        while (sclLine !== 1'b1) begin
            tick(1);
        end
        tick(1);
        @(negedge clk);
        r = sdaLine;
        tick(2);
        sclOeN <= 1'b0;
        tick(2);
    endtask

    // Eight bits MSB first, then the ninth-clock acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], r);
        end
        clock_bit(1'b1, ack);
    endtask

    // Releases SDA for eight bits, then answers with ackBit
    task automatic recv_byte(input logic ackBit, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, r);
            d[i] = r;
        end
        clock_bit(ackBit, r);
    endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the two-wire slave port and its registers.
// Assumes a pulled-up bus shared with the master model and a single
// AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module tb;
    localparam logic [6:0] ownAddr = 7'h5a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic sclOeN, sdaOeN, mstSclOeN, mstSdaOeN, irqReq, ack;
    logic sclOut, sdaOut;
    wire logic sclLine, sdaLine;
    logic [31:0] rd;
    logic [7:0] d;
    logic [2:0] badModes [2] = '{3'h7, 3'h5};
    int badCount = 0;
    int nChecks = 0;
    int irqCount = 0;
    int cycles = 0;
    int n0;

    always #25 clk = ~clk;

    // Pulled-up open-drain lines; an enabled slave pin shows its out value
    assign sclLine = (sclOeN | sclOut) & mstSclOeN;
    assign sdaLine = (sdaOeN | sdaOut) & mstSdaOeN;

    i2c_slave_serial_port i2c_slave_serial_port_i (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(), .sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .irqReq(irqReq)
    );

    i2c_master_model i2c_master_model_i (
        .clk(clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclOeN(mstSclOeN), .sdaOeN(mstSdaOeN)
    );

    // Interrupt pulses are one cycle, so count every high edge
    always @(posedge clk) begin
        if (irqReq === 1'b1) begin
            irqCount <= irqCount + 1;
        end
    end

    // Cut a hang short; the run needs far fewer cycles than this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            badCount++;
            giveVerdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic giveVerdict();
        if (badCount == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // No wait count is assumed; the cycle ceiling ends a hang
    task automatic wait_ready();
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
        end
    endtask

    // Single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask

    // Main sequence: reset values, modes, then both transfer kinds
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL0, 32'h0, rd);
        check(rd, {24'h0, i2c_slave_pkg::CTRL0_RESET});
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check(rd, 32'h0);
        xfer(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h0);
        foreach (badModes[k]) begin
            xfer(1'b1, i2c_slave_pkg::OFS_CTRL0,
                 {24'h0, badModes[k], 5'h2}, rd);
            xfer(1'b1, i2c_slave_pkg::OFS_ADDR, {24'h0, ownAddr, 1'b1}, rd);
            i2c_master_model_i.start_cond();
            i2c_master_model_i.send_byte({ownAddr, 1'b0}, ack);
            check({31'h0, ack}, 32'h1);
            i2c_master_model_i.stop_cond();
        end
        xfer(1'b1, i2c_slave_pkg::OFS_CTRL0, 32'hc2, rd);
        xfer(1'b1, i2c_slave_pkg::OFS_ADDR, {24'h0, ownAddr, 1'b1}, rd);
        n0 = irqCount;
        i2c_master_model_i.start_cond();
        i2c_master_model_i.send_byte({ownAddr ^ 7'h01, 1'b0}, ack);
        check({31'h0, ack}, 32'h1);
        i2c_master_model_i.stop_cond();
        check(32'(irqCount), 32'(n0));
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::BUSY_BIT]}, 32'h0);
        // Master writes two bytes; the second one is refused
        i2c_master_model_i.start_cond();
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::BUSY_BIT]}, 32'h1);
        i2c_master_model_i.send_byte({ownAddr, 1'b0}, ack);
        check({31'h0, ack}, 32'h0);
        repeat (20) @(posedge clk);
        check(32'(irqCount), 32'(n0 + 1));
        check({31'h0, sclOeN}, 32'h0);
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::MATCHED_BIT]}, 32'h1);
        check({31'h0, rd[i2c_slave_pkg::DIR_BIT]}, 32'h0);
        xfer(1'b1, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        xfer(1'b0, i2c_slave_pkg::OFS_DATA, 32'h0, rd);
        repeat (6) @(posedge clk);
        check({31'h0, sclOeN}, 32'h1);
        i2c_master_model_i.send_byte(8'ha5, ack);
        check({31'h0, ack}, 32'h0);
        repeat (6) @(posedge clk);
        check(32'(irqCount), 32'(n0 + 2));
        xfer(1'b1, i2c_slave_pkg::OFS_CTRL1, 32'h8, rd);
        xfer(1'b0, i2c_slave_pkg::OFS_DATA, 32'h0, rd);
        check(rd, 32'ha5);
        i2c_master_model_i.send_byte(8'h3c, ack);
        check({31'h0, ack}, 32'h1);
        xfer(1'b0, i2c_slave_pkg::OFS_DATA, 32'h0, rd);
        check(rd, 32'h3c);
        i2c_master_model_i.stop_cond();
        // Master reads two bytes; it refuses the second one
        n0 = irqCount;
        i2c_master_model_i.start_cond();
        i2c_master_model_i.send_byte({ownAddr, 1'b1}, ack);
        check({31'h0, ack}, 32'h0);
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::DIR_BIT]}, 32'h1);
        xfer(1'b1, i2c_slave_pkg::OFS_CTRL1, 32'h10, rd);
        xfer(1'b1, i2c_slave_pkg::OFS_DATA, 32'hc3, rd);
        i2c_master_model_i.recv_byte(1'b0, d);
        check({24'h0, d}, 32'hc3);
        repeat (6) @(posedge clk);
        check(32'(irqCount), 32'(n0 + 2));
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::ACKRCV_BIT]}, 32'h0);
        xfer(1'b1, i2c_slave_pkg::OFS_DATA, 32'h81, rd);
        i2c_master_model_i.recv_byte(1'b1, d);
        check({24'h0, d}, 32'h81);
        repeat (8) @(posedge clk);
        check({30'h0, sdaOeN, sclOeN}, 32'h3);
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::ACKRCV_BIT]}, 32'h1);
        i2c_master_model_i.stop_cond();
        xfer(1'b0, i2c_slave_pkg::OFS_CTRL1, 32'h0, rd);
        check({31'h0, rd[i2c_slave_pkg::BUSY_BIT]}, 32'h0);
        giveVerdict();
    end
endmodule
